// *** core/kg_fifo.sv ***
// block fifo with valid/ready on both sides and a synchronous flush
// assumes synchronous active-high reset and a shared clock enable
module kg_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  kg_fifo_if.fifo  port
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } kg_fifo_s;

  kg_fifo_s r_reg;
  kg_fifo_s r_next;
  logic     push;
  logic     pop;

  assign port.wr_ready = (r_reg.cnt != (AW+1)'(DEPTH));
  assign port.rd_valid = (r_reg.cnt != '0);
  assign port.rd_data  = r_reg.mem[r_reg.rp];

  always_comb
  begin
    r_next = r_reg;
    push   = port.wr_valid && port.wr_ready;
    pop    = port.rd_valid && port.rd_ready;
    if (port.flush)
    begin
      r_next.wp  = '0;
      r_next.rp  = '0;
      r_next.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        r_next.mem[r_reg.wp] = port.wr_data;
        r_next.wp            = (r_reg.wp == AW'(DEPTH-1)) ? '0 : r_reg.wp + 1'b1;
      end
      if (pop)
        r_next.rp = (r_reg.rp == AW'(DEPTH-1)) ? '0 : r_reg.rp + 1'b1;
      r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      r_reg <= '0;
    else if (i_ce)
      r_reg <= r_next;
  end
endmodule // kg_fifo

// *** core/kg_fifo_if.sv ***
// block carrier between keystream generator and its block fifo
// assumes both ends share one clock
interface kg_fifo_if #(parameter int WIDTH = 128);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic             flush;
  modport fifo (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data);
endinterface : kg_fifo_if

// *** core/kg_pkg.sv ***
// constants and types shared by the keystream generator files
// assumes one clock; key, vector and demand come from logic on that clock
package kg_pkg;
  localparam int          KEY_BITS       = 128;
  localparam int          IV_BITS        = 64;
  localparam int          LEGACY_BITS    = 64;
  localparam int          BLOCK_BITS     = 128;
  localparam int          BLOCK_SHIFT    = 7;
  localparam int          SEQ_PER_LOAD   = 2;
  localparam int          MAX_SEQ_BITS   = 4840;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          AES_ROUNDS     = 10;
  localparam logic [7:0]  AES_RCON_FIRST = 8'h01;
  localparam logic [7:0]  AES_POLY       = 8'h1b;
  localparam logic [7:0]  AES_AFFINE     = 8'h63;

  typedef enum logic [1:0] {KG_IDLE, KG_ROUND, KG_PUSH} kg_gen_e;
endpackage : kg_pkg

// *** core/kg_top.sv ***
// keystream generator: key mapping, counter-mode AES-128, block fifo, bit serialiser
// assumes all inputs come from logic on I_CLOCK; no synchronisers needed
module kg_top #(
  parameter int FIFO_DEPTH = kg_pkg::FIFO_DEPTH
) (
  input  wire logic         I_CLOCK,
  input  wire logic         I_SYS_RST,
  input  wire logic         I_CLK_EN,
  input  wire logic         I_LOAD,
  input  wire logic         I_MODE,
  input  wire logic [127:0] I_DERIVED_CIPHER_KEY,
  input  wire logic [7:0]   I_KEY_LEN,
  input  wire logic [63:0]  I_INIT_VECTOR,
  input  wire logic [6:0]   I_IV_LEN,
  input  wire logic         I_SEQ_REQ,
  input  wire logic [12:0]  I_SEQ_LEN,
  input  wire logic         I_KS_READY,
  input  wire logic         I_PT_BIT,
  output logic              O_KS_VALID,
  output logic              O_KS_BIT,
  output logic              O_CT_VALID,
  output logic              O_CT_BIT,
  output logic              O_SEQ_DONE,
  output logic              O_LOAD_ERR,
  output logic              O_IDLE
);
  // ****************************************************************
  // aes helpers
  // ****************************************************************
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? kg_pkg::AES_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // inverse as x^254, then affine map
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] sq;
    logic [7:0] r;
    sq = a;
    r  = 8'h01;
    for (int k = 0; k < 7; k++)
    begin
      sq = gmul(sq, sq);
      r  = gmul(r, sq);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]}
           ^ kg_pkg::AES_AFFINE;
  endfunction

  function automatic logic [127:0] next_rk(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] t;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    t  = {sbox(k[23:16]), sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])} ^ {rc, 24'h000000};
    w0 = k[127:96] ^ t;
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    return {w0, w1, w2, w3};
  endfunction

  function automatic logic [127:0] aes_round(input logic [127:0] s, input logic last,
                                             input logic [127:0] k);
    logic [7:0]   t [16];
    logic [7:0]   u [16];
    logic [127:0] o;
    for (int i = 0; i < 16; i++)
      t[i] = sbox(s[127-8*i -: 8]);
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        u[r+4*c] = t[r+4*((c+r)%4)];
    for (int c = 0; c < 4; c++)
    begin
      if (last)
        for (int r = 0; r < 4; r++)
          o[127-8*(4*c+r) -: 8] = u[4*c+r];
      else
        for (int r = 0; r < 4; r++)
          o[127-8*(4*c+r) -: 8] = xt(u[4*c+r]) ^ xt(u[4*c+(r+1)%4]) ^ u[4*c+(r+1)%4]
                                  ^ u[4*c+(r+2)%4] ^ u[4*c+(r+3)%4];
    end
    return o ^ k;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    kg_pkg::kg_gen_e fsm;
    logic [127:0]    key;
    logic [63:0]     iv;
    logic [63:0]     blk_idx;
    logic [127:0]    st;
    logic [127:0]    rk;
    logic [3:0]      rnd;
    logic [7:0]      rcon;
    logic            loaded;
    logic [1:0]      seq_cnt;
    logic [6:0]      blk_left;
    logic [12:0]     bits_left;
    logic [127:0]    sh;
    logic [7:0]      sh_cnt;
    logic            ks_valid;
    logic            ks_bit;
    logic            ct_valid;
    logic            ct_bit;
    logic            done;
    logic            err;
    logic            idle;
  } kg_top_s;

  kg_top_s         r_reg;
  kg_top_s         r_next;
  logic [127:0]    legacy_ck;
  logic [127:0]    key_mask;
  logic [63:0]     iv_mask;
  logic [7:0]      eff_len;
  logic [127:0]    rk_new;
  logic            accept;
  logic            seq_ok;

  kg_fifo_if #(.WIDTH(kg_pkg::BLOCK_BITS)) blk_q ();

  kg_fifo #(
    .WIDTH (kg_pkg::BLOCK_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk (I_CLOCK),
    .i_rst (I_SYS_RST),
    .i_ce  (I_CLK_EN),
    .port  (blk_q.fifo)
  );

  // ****************************************************************
  // key and vector mapping
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < kg_pkg::LEGACY_BITS/8; g++)
    begin : g_rev
      assign legacy_ck[127-8*g -: 8] = I_DERIVED_CIPHER_KEY[127-8*(7-g) -: 8];
    end
  endgenerate
  assign legacy_ck[63:0] = '0;

  assign eff_len  = (I_KEY_LEN > 8'(kg_pkg::KEY_BITS)) ? 8'(kg_pkg::KEY_BITS) : I_KEY_LEN;
  assign key_mask = ~({128{1'b1}} >> eff_len);
  assign iv_mask  = (I_IV_LEN >= 7'(kg_pkg::IV_BITS)) ? {64{1'b1}}
                    : ~({64{1'b1}} << I_IV_LEN);
  assign rk_new   = next_rk(r_reg.rk, r_reg.rcon);

  assign accept = r_reg.ks_valid && I_KS_READY;
  assign seq_ok = r_reg.loaded && (r_reg.seq_cnt != 2'(kg_pkg::SEQ_PER_LOAD))
                  && (I_SEQ_LEN != '0) && (I_SEQ_LEN <= 13'(kg_pkg::MAX_SEQ_BITS))
                  && (r_reg.bits_left == '0) && (r_reg.blk_left == '0) && !r_reg.ks_valid;

  assign blk_q.wr_valid = (r_reg.fsm == kg_pkg::KG_PUSH);
  assign blk_q.wr_data  = r_reg.st;
  assign blk_q.rd_ready = (r_reg.sh_cnt == '0) && (r_reg.bits_left != '0);
  assign blk_q.flush    = I_LOAD;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    // counter-mode block engine, one round per cycle
    case (r_reg.fsm)
      kg_pkg::KG_IDLE:
        if (r_reg.blk_left != '0)
        begin
          r_next.st   = {r_reg.iv, r_reg.blk_idx} ^ r_reg.key;
          r_next.rk   = r_reg.key;
          r_next.rnd  = 4'h1;
          r_next.rcon = kg_pkg::AES_RCON_FIRST;
          r_next.fsm  = kg_pkg::KG_ROUND;
        end
      kg_pkg::KG_ROUND:
      begin
        r_next.rk   = rk_new;
        r_next.st   = aes_round(r_reg.st, r_reg.rnd == 4'(kg_pkg::AES_ROUNDS), rk_new);
        r_next.rcon = xt(r_reg.rcon);
        r_next.rnd  = r_reg.rnd + 1'b1;
        if (r_reg.rnd == 4'(kg_pkg::AES_ROUNDS))
          r_next.fsm = kg_pkg::KG_PUSH;
      end
      kg_pkg::KG_PUSH:
        if (blk_q.wr_ready)
        begin
          r_next.blk_idx  = r_reg.blk_idx + 1'b1;
          r_next.blk_left = r_reg.blk_left - 1'b1;
          r_next.fsm      = kg_pkg::KG_IDLE;
        end
      default:
        r_next.fsm = kg_pkg::KG_IDLE;
    endcase

    // serialiser, first cipher bit first
    if (blk_q.rd_valid && blk_q.rd_ready)
    begin
      r_next.sh     = blk_q.rd_data;
      r_next.sh_cnt = 8'(kg_pkg::BLOCK_BITS);
    end
    if (!r_reg.ks_valid || I_KS_READY)
    begin
      if (r_reg.sh_cnt != '0 && r_reg.bits_left != '0)
      begin
        r_next.ks_bit    = r_reg.sh[127];
        r_next.ks_valid  = 1'b1;
        r_next.sh        = {r_reg.sh[126:0], 1'b0};
        r_next.bits_left = r_reg.bits_left - 1'b1;
        // truncated block tail is dropped
        r_next.sh_cnt    = (r_reg.bits_left == 13'h0001) ? 8'h00 : r_reg.sh_cnt - 1'b1;
      end
      else
        r_next.ks_valid = 1'b0;
    end
    r_next.ct_valid = accept;
    if (accept)
      r_next.ct_bit = r_reg.ks_bit ^ I_PT_BIT;
    if (accept && r_reg.bits_left == '0)
      r_next.done = 1'b1;

    if (I_SEQ_REQ && seq_ok)
    begin
      r_next.seq_cnt   = r_reg.seq_cnt + 1'b1;
      r_next.bits_left = I_SEQ_LEN;
      r_next.blk_left  = 7'((14'(I_SEQ_LEN) + 14'(kg_pkg::BLOCK_BITS - 1)) >> kg_pkg::BLOCK_SHIFT);
    end

    if (I_LOAD)
    begin
      r_next.err = I_MODE == 1'b0 && I_KEY_LEN > 8'(kg_pkg::LEGACY_BITS);
      r_next.fsm       = kg_pkg::KG_IDLE;
      r_next.blk_idx   = '0;
      r_next.blk_left  = '0;
      r_next.bits_left = '0;
      r_next.sh_cnt    = '0;
      r_next.ks_valid  = 1'b0;
      r_next.ct_valid  = 1'b0;
      r_next.done      = 1'b0;
      r_next.seq_cnt   = '0;
      r_next.loaded    = !r_next.err;
      r_next.iv        = I_INIT_VECTOR & iv_mask;
      r_next.key       = (I_MODE ? I_DERIVED_CIPHER_KEY : legacy_ck) & key_mask;
    end

    r_next.idle = r_next.loaded && r_next.fsm == kg_pkg::KG_IDLE && r_next.blk_left == '0
                  && r_next.bits_left == '0 && !r_next.ks_valid
                  && r_next.seq_cnt != 2'(kg_pkg::SEQ_PER_LOAD);
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      r_reg <= '0;
    else if (I_CLK_EN)
      r_reg <= r_next;
  end

  assign O_KS_VALID = r_reg.ks_valid;
  assign O_KS_BIT   = r_reg.ks_bit;
  assign O_CT_VALID = r_reg.ct_valid;
  assign O_CT_BIT   = r_reg.ct_bit;
  assign O_SEQ_DONE = r_reg.done;
  assign O_LOAD_ERR = r_reg.err;
  assign O_IDLE     = r_reg.idle;
endmodule // kg_top

// *** verif/kg_sink.sv ***
// keystream consumer standing in for the link framing logic
// assumes one clock; ready and plaintext change at the falling edge
module kg_sink (
  input  wire logic    i_clk,
  input  wire logic    i_slow,
  input  wire logic    i_ks_valid,
  input  wire logic    i_ks_bit,
  input  wire logic    i_ct_valid,
  input  wire logic    i_ct_bit,
  output logic         o_ready,
  output logic         o_pt_bit,
  output logic [127:0] o_window,
  output int           o_count,
  output int           o_ct_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // accept, record, check ciphertext
  // ****************
  logic [3:0] phase = 4'h0;
  logic       exp_ct = 1'b0;
  initial
  begin
    o_ready  = 1'b0;
    o_pt_bit = 1'b0;
    o_window = '0;
    o_count  = 0;
    o_ct_bad = 0;
  end
  // slow mode stalls three cycles out of four
  always @(negedge i_clk)
  begin
    phase    <= phase + 4'h1;
    o_ready  <= !i_slow || (phase[1:0] == 2'h0);
    o_pt_bit <= phase[0] ^ phase[2];
  end
  // newest bit at the bottom, so a full block reads msb first
  always @(posedge i_clk)
  begin
    if (i_ks_valid && o_ready)
    begin
      o_window <= {o_window[126:0], i_ks_bit};
      o_count  <= o_count + 1;
      exp_ct   <= i_ks_bit ^ o_pt_bit;
    end
    if (i_ct_valid && (i_ct_bit !== exp_ct))
      o_ct_bad <= o_ct_bad + 1;
  end
endmodule // kg_sink

// *** verif/kg_top_properties.sv ***
// checker on the keystream generator top ports
// assumes it is bound into kg_top; one clock, sync reset
module kg_top_properties (
  input wire logic       I_CLOCK,
  input wire logic       I_SYS_RST,
  input wire logic       I_CLK_EN,
  input wire logic       I_LOAD,
  input wire logic       I_MODE,
  input wire logic [7:0] I_KEY_LEN,
  input wire logic       I_KS_READY,
  input wire logic       I_PT_BIT,
  input wire logic       O_KS_VALID,
  input wire logic       O_KS_BIT,
  input wire logic       O_CT_VALID,
  input wire logic       O_CT_BIT,
  input wire logic       O_SEQ_DONE,
  input wire logic       O_IDLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  // ****************
  // port relations
  // ****************
  ct_cause_a: assert property (O_CT_VALID |-> $past(O_KS_VALID && I_KS_READY))
    else $error("ciphertext bit without accept");
  ct_value_a: assert property (O_CT_VALID |-> O_CT_BIT == $past(O_KS_BIT ^ I_PT_BIT))
    else $error("ciphertext bit wrong");
  ct_issue_a: assert property ((I_CLK_EN && O_KS_VALID && I_KS_READY && !I_LOAD)
    |=> O_CT_VALID) else $error("accepted bit gave no ciphertext");
  ks_hold_a: assert property ((O_KS_VALID && !I_KS_READY && !I_LOAD)
    |=> (O_KS_VALID && $stable(O_KS_BIT))) else $error("keystream bit not held");
  good_load_a: assert property ((I_CLK_EN && I_LOAD && (I_MODE || I_KEY_LEN <= 8'h40))
    |=> (O_IDLE && !O_KS_VALID)) else $error("good load not answered");
  bad_load_a: assert property ((I_CLK_EN && I_LOAD && !I_MODE && I_KEY_LEN > 8'h40)
    |=> (!O_IDLE && !O_KS_VALID)) else $error("long legacy key accepted");
  done_pulse_a: assert property (O_SEQ_DONE |-> O_CT_VALID ##1 !O_SEQ_DONE)
    else $error("done pulse wrong");
  done_stop_a: assert property (O_SEQ_DONE |-> !O_KS_VALID)
    else $error("keystream past sequence end");
  idle_quiet_a: assert property (O_IDLE |-> !O_KS_VALID)
    else $error("keystream while idle");
endmodule // kg_top_properties

bind kg_top kg_top_properties u_props (
  .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_CLK_EN(I_CLK_EN), .I_LOAD(I_LOAD),
  .I_MODE(I_MODE), .I_KEY_LEN(I_KEY_LEN), .I_KS_READY(I_KS_READY), .I_PT_BIT(I_PT_BIT),
  .O_KS_VALID(O_KS_VALID), .O_KS_BIT(O_KS_BIT), .O_CT_VALID(O_CT_VALID),
  .O_CT_BIT(O_CT_BIT), .O_SEQ_DONE(O_SEQ_DONE), .O_IDLE(O_IDLE)
);

// *** verif/kg_top_tb.sv ***
// self-checking bench for the keystream generator top
// assumes kg_sink consumes keystream; inputs change at the falling edge
module kg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] K11 = 128'h5e9d489c191661726b7232e6401d71f0;
  localparam logic [127:0] C0  = 128'hb5d23e32b712b63e376360fb522cb1f5;
  localparam logic [127:0] C1  = 128'h1edd0ed98b5553477227ca871b8e652a;
  localparam logic [63:0]  V11 = 64'h03847f4f494a0677;
  logic         clock = 1'b0, rst = 1'b1, clk_en = 1'b1, load = 1'b0, mode = 1'b0;
  logic         seq_req = 1'b0, slow = 1'b0;
  logic [127:0] derived_cipher_key = '0;
  logic [7:0]   key_len = '0;
  logic [63:0]  iv = '0;
  logic [6:0]   iv_len = '0;
  logic [12:0]  seq_len = '0;
  logic         ready, pt, ks_valid, ks_bit, ct_valid, ct_bit, seq_done, load_err, idle;
  logic [127:0] window;
  int           count, ct_bad, mismatches = 0, check_count = 0;

  always #4 clock = ~clock;

  kg_top uut (
    .I_CLOCK(clock), .I_SYS_RST(rst), .I_CLK_EN(clk_en), .I_LOAD(load), .I_MODE(mode),
    .I_DERIVED_CIPHER_KEY(derived_cipher_key), .I_KEY_LEN(key_len), .I_INIT_VECTOR(iv), .I_IV_LEN(iv_len),
    .I_SEQ_REQ(seq_req), .I_SEQ_LEN(seq_len), .I_KS_READY(ready), .I_PT_BIT(pt),
    .O_KS_VALID(ks_valid), .O_KS_BIT(ks_bit), .O_CT_VALID(ct_valid), .O_CT_BIT(ct_bit),
    .O_SEQ_DONE(seq_done), .O_LOAD_ERR(load_err), .O_IDLE(idle)
  );
  kg_sink sink (
    .i_clk(clock), .i_slow(slow), .i_ks_valid(ks_valid), .i_ks_bit(ks_bit),
    .i_ct_valid(ct_valid), .i_ct_bit(ct_bit), .o_ready(ready), .o_pt_bit(pt),
    .o_window(window), .o_count(count), .o_ct_bad(ct_bad)
  );
  // ****************
  // shared tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({127'h0, got}, {127'h0, exp});
  endtask
  task automatic tick(inout int n, input int lim);
    @(negedge clock);
    n++;
    if (n > lim)
    begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic do_load(input logic m, input logic [127:0] k, input logic [7:0] kl,
                         input logic [63:0] v, input logic [6:0] vl);
    @(negedge clock);
    load = 1'b1;
    mode = m;
    derived_cipher_key = k;
    key_len = kl;
    iv = v;
    iv_len = vl;
    @(negedge clock);
    load = 1'b0;
  endtask
  task automatic request(input logic [12:0] len, input logic need_idle);
    int n;
    n = 0;
    while (need_idle && idle !== 1'b1)
      tick(n, 300);
    @(negedge clock);
    seq_req = 1'b1;
    seq_len = len;
    @(negedge clock);
    seq_req = 1'b0;
  endtask
  task automatic wait_bits(input int target);
    int n;
    n = 0;
    while (count < target)
      tick(n, 20000);
  endtask
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge clock);
      cmp_bit(ks_valid, 1'b0);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic test_second_mode();
    int base;
    do_load(1'b1, K11, 8'h80, V11, 7'h40);
    cmp_bit(idle, 1'b1);
    cmp_bit(load_err, 1'b0);
    base = count;
    request(13'd100, 1'b1);
    wait_bits(base + 100);
    cmp_bit(seq_done, 1'b1);
    cmp_word({28'h0, window[99:0]}, {28'h0, C0[127:28]});
    quiet(20);
    slow = 1'b1;
    request(13'd128, 1'b1);
    wait_bits(base + 228);
    cmp_bit(seq_done, 1'b1);
    cmp_word(window, C1);
    request(13'd128, 1'b0);
    quiet(30);
    slow = 1'b0;
  endtask
  task automatic test_reload();
    int base;
    do_load(1'b1, K11, 8'h80, V11, 7'h40);
    slow = 1'b1;
    request(13'd256, 1'b1);
    wait_bits(count + 40);
    cmp_bit(seq_done, 1'b0);
    do_load(1'b1, K11, 8'h80, V11, 7'h40);
    cmp_bit(ks_valid, 1'b0);
    base = count;
    request(13'd128, 1'b1);
    wait_bits(base + 128);
    cmp_word(window, C0);
    slow = 1'b0;
  endtask
  task automatic test_key_mask();
    int base;
    do_load(1'b1, 128'h3bf63a9e797d5f490ddc4cad314f7fff, 8'h72, 64'hc9442e4013661cd0, 7'h3f);
    base = count;
    request(13'd128, 1'b1);
    wait_bits(base + 128);
    cmp_word(window, 128'h28b505f59336d2abf4e98e657b751544);
  endtask
  task automatic test_legacy();
    int base;
    do_load(1'b0, 128'h00000060b77e3042ffffffffffffffff, 8'h40, 64'h409d12e1798b121f, 7'h40);
    cmp_bit(idle, 1'b1);
    slow = 1'b1;
    base = count;
    request(13'd2048, 1'b1);
    wait_bits(base + 2048);
    cmp_bit(seq_done, 1'b1);
    cmp_word(window, 128'h8ece05e64ec7f08abadfb26950382207);
    slow = 1'b0;
  endtask
  task automatic test_refused();
    do_load(1'b0, K11, 8'h41, V11, 7'h40);
    cmp_bit(load_err, 1'b1);
    cmp_bit(idle, 1'b0);
    request(13'd16, 1'b0);
    quiet(30);
    do_load(1'b1, K11, 8'h80, V11, 7'h40);
    cmp_bit(load_err, 1'b0);
    cmp_bit(idle, 1'b1);
  endtask
  initial
  begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    cmp_bit(idle, 1'b0);
    test_second_mode();
    test_reload();
    test_key_mask();
    test_legacy();
    test_refused();
    cmp_word(128'(ct_bad), '0);
    complete_run();
  end
endmodule // kg_top_tb
